// [cfg_loader_pkg.sv]
// Shared constants and types for the serial configuration loader
package cfg_loader_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing, times in ns at a 200 MHz core clock, except WAIT_MIN_REF in reference clock periods
  localparam int CLK_NS       = 5;
  localparam int REF_CLK_NS   = 100;
  localparam int WAIT_MIN_REF = 6;
  localparam int WAIT_NS      = 650;
  localparam int HALF_NS      = 800;
  // Least times round up to whole cycles
  localparam int WAIT_CYC     = (WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAIT_MIN_CYC = (WAIT_MIN_REF * REF_CLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_CYC     = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] WAIT_LAST = 8'(WAIT_CYC - 1);
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame layout
  localparam int BYTE_BITS = 8;
  localparam int NUM_BYTES = 8;
  localparam int DATA_BITS = BYTE_BITS * NUM_BYTES;
  localparam int CMD_BITS  = 10;
  localparam logic [2:0] READ_OP = 3'h6;
  localparam logic [6:0] ADDR_START_MARKER = 7'h00;
  localparam logic [CMD_BITS-1:0] READ_CMD = {READ_OP, ADDR_START_MARKER};

  // Byte addresses inside the image
  localparam int ADDR_START = 0;
  localparam int ADDR_LINK  = 1;
  localparam int ADDR_PIXEL = 2;
  localparam int ADDR_FAULT = 3;
  localparam int ADDR_PLL   = 4;
  localparam int ADDR_RSVD5 = 5;
  localparam int ADDR_RSVD6 = 6;
  localparam int ADDR_END   = 7;

  localparam logic [7:0] CONFIG_START_MARKER = 8'hbd;
  localparam logic [7:0] CONFIG_END_MARKER   = 8'h99;

  // Field positions
  localparam int WAKE1_BIT   = 1;
  localparam int BW_MODE_BIT = 6;
  localparam int UP_CLK_LSB  = 6;
  localparam int WAKE2_BIT   = 1;
  localparam int WAKE3_BIT   = 2;
  localparam int FAULT_LSB   = 4;

  // Default bytes 1 to 6
  localparam logic [7:0] DEF_LINK  = 8'hc9;
  localparam logic [7:0] DEF_PIXEL = 8'h7c;
  localparam logic [7:0] DEF_FAULT = 8'h08;
  localparam logic [7:0] DEF_PLL   = 8'h0c;
  localparam logic [7:0] DEF_RSVD5 = 8'h01;
  localparam logic [7:0] DEF_RSVD6 = 8'h00;

  // Fault source select codes
  localparam logic [3:0] FSEL_NO_VIDEO = 4'h0;
  localparam logic [3:0] FSEL_PIX_LOCK = 4'h1;
  localparam logic [3:0] FSEL_LINK_UP  = 4'h2;
  localparam logic [3:0] FSEL_SECOND_VIDEO_CONTROL    = 4'h3;
  localparam logic [3:0] FSEL_BUFFER   = 4'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {ST_WAIT, ST_CMD, ST_READ, ST_DONE} load_state_t;

  typedef enum logic [2:0] {RATE_OFF, RATE_62M5, RATE_41M67, RATE_31M25, RATE_20M83} up_rate_t;

  typedef struct packed {
    logic [7:0] rsvd6;
    logic [7:0] rsvd5;
    logic [7:0] pll;
    logic [7:0] fault;
    logic [7:0] pixel;
    logic [7:0] link;
  } config_image_t;

  localparam config_image_t CFG_DEFAULT =
    '{DEF_RSVD6, DEF_RSVD5, DEF_PLL, DEF_FAULT, DEF_PIXEL, DEF_LINK};

  typedef struct packed {
    logic no_video;
    logic pixel_lock;
    logic link_up;
    logic second_video_control_sync;
    logic buf_full;
    logic buf_empty;
    logic video_timing_ok;
  } link_status_t;

  typedef struct packed {
    logic       pix_clk;
    logic [1:0] sb_bits;
    logic       sb_clk;
  } pixel_side_t;

  typedef struct packed {
    load_state_t          st;
    logic [7:0]           cnt;
    logic                 high;
    logic [6:0]           bits;
    logic [DATA_BITS-1:0] shift;
    logic                 clk_o;
    logic                 d_o;
    logic                 d_oe;
    config_image_t        cfg;
    logic                 done;
    logic                 valid;
    logic                 fault;
    up_rate_t             rate;
    logic                 wake;
    pixel_side_t          side;
  } loader_state_t;

endpackage

// [sync_two_stage.sv]
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module sync_two_stage #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // One stage pair per bit; first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_reg;
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        meta_reg <= 1'b0;
        q[i]     <= 1'b0;
      end else begin
        meta_reg <= d[i];
        q[i]     <= meta_reg;
      end
    end
  end

endmodule

// [serial_config_loader_reset.sv]
// Serial configuration loader with reset-state control of the pixel side outputs
`timescale 1ns/100ps
module serial_config_loader_reset
  import cfg_loader_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          resetn,
  // Serial memory interface, device is master
  output logic               cfg_clk_out,
  input  wire logic          cfg_data_in,
  output logic               cfg_data_out,
  output logic               cfg_data_oe,
  // Link status pins from the receive datapath
  input  wire link_status_t  status_in,
  // Pixel side requests from the datapath, same clock
  input  wire pixel_side_t   side_in,
  input  wire logic [23:0]   pixel_word_in,
  input  wire logic [2:0]    pixel_control_in,
  // Pixel side pins
  output logic               pixel_clk_out,
  output logic [23:0]        pixel_word_out,
  output logic [2:0]         pixel_control_out,
  output logic [1:0]         sideband_down_bits,
  output logic               sideband_down_clock,
  // Applied configuration and results
  output config_image_t      active_cfg,
  output up_rate_t           upstream_rate,
  output logic               fault_out,
  output logic               wake_enable,
  output logic               cfg_done,
  output logic               cfg_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [7:0]   sy_bus;
  link_status_t sy_stat;
  logic         sy_data;

  sync_two_stage #(.W(8)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({status_in, cfg_data_in}),
    .q      (sy_bus)
  );

  // Split synchronised bus into status and serial data
  assign sy_stat = link_status_t'(sy_bus[7:1]);
  assign sy_data = sy_bus[0];

  ////////////////////////////////////////////////////////////////////////////////
  // State

  localparam loader_state_t RESET_STATE = '{
    st:    ST_WAIT,
    cnt:   8'h00,
    high:  1'b0,
    bits:  7'h00,
    shift: '0,
    clk_o: 1'b0,
    d_o:   1'b0,
    d_oe:  1'b0,
    cfg:   CFG_DEFAULT,
    done:  1'b0,
    valid: 1'b0,
    fault: 1'b0,
    rate:  RATE_OFF,
    wake:  1'b0,
    side:  '0
  };

  loader_state_t cur_reg;
  loader_state_t cur_next;

  // Byte at a given address of the received stream, first byte in the top bits
  function automatic logic [7:0] image_byte(input logic [DATA_BITS-1:0] s, input int a);
    image_byte = s[(DATA_BITS - 1 - BYTE_BITS * a) -: BYTE_BITS];
  endfunction

  // Upstream line rate from bandwidth mode and two-bit field
  function automatic up_rate_t pick_rate(input logic half_bw, input logic [1:0] fld);
    up_rate_t r;
    r = RATE_OFF;
    if (!half_bw) begin
      case (fld)
        2'h1:    r = RATE_62M5;
        2'h2:    r = RATE_41M67;
        2'h3:    r = RATE_31M25;
        default: r = RATE_OFF;
      endcase
    end else begin
      case (fld)
        2'h0:    r = RATE_62M5;
        2'h1:    r = RATE_31M25;
        2'h2:    r = RATE_20M83;
        default: r = RATE_OFF;
      endcase
    end
    return r;
  endfunction

  // Error pin source, reserved codes hold the pin low
  function automatic logic pick_fault(input logic [3:0] sel, input link_status_t s);
    logic f;
    f = 1'b0;
    case (sel)
      FSEL_NO_VIDEO: f = s.no_video;
      FSEL_PIX_LOCK: f = ~s.pixel_lock;
      FSEL_LINK_UP:  f = s.link_up;
      FSEL_SECOND_VIDEO_CONTROL:    f = s.second_video_control_sync;
      FSEL_BUFFER:   f = s.buf_full | s.buf_empty;
      default:       f = 1'b0;
    endcase
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic                 tick;
  logic                 markers_ok;
  config_image_t        loaded;
  logic [3:0]           cmd_idx;

  always_comb begin
    cur_next = cur_reg;
    // One wait count after reset, then half periods of the serial clock
    tick = (cur_reg.cnt == ((cur_reg.st == ST_WAIT) ? WAIT_LAST : HALF_LAST));
    markers_ok = (image_byte(cur_reg.shift, ADDR_START) == CONFIG_START_MARKER) &&
                 (image_byte(cur_reg.shift, ADDR_END) == CONFIG_END_MARKER);
    loaded = '{image_byte(cur_reg.shift, ADDR_RSVD6), image_byte(cur_reg.shift, ADDR_RSVD5),
               image_byte(cur_reg.shift, ADDR_PLL), image_byte(cur_reg.shift, ADDR_FAULT),
               image_byte(cur_reg.shift, ADDR_PIXEL), image_byte(cur_reg.shift, ADDR_LINK)};
    cmd_idx = 4'(CMD_BITS - 2) - cur_reg.bits[3:0];
    if (!tick) begin
      cur_next.cnt = cur_reg.cnt + 8'h01;
    end else if (cur_reg.st != ST_DONE) begin
      cur_next.cnt = 8'h00;
    end
    case (cur_reg.st)
      ST_WAIT: begin
        // Clock stays low until the wait has run out
        if (tick) begin
          cur_next.st   = ST_CMD;
          cur_next.bits = 7'h00;
          cur_next.high = 1'b0;
          cur_next.d_oe = 1'b1;
          cur_next.d_o  = READ_CMD[CMD_BITS-1];
        end
      end
      ST_CMD, ST_READ: begin
        if (tick && !cur_reg.high) begin
          // Rising edge: memory takes command bit, we take data bit
          cur_next.high  = 1'b1;
          cur_next.clk_o = 1'b1;
          if (cur_reg.st == ST_READ) begin
            cur_next.shift = {cur_reg.shift[DATA_BITS-2:0], sy_data};
          end
        end else if (tick) begin
          // Falling edge: advance to the next bit
          cur_next.high  = 1'b0;
          cur_next.clk_o = 1'b0;
          cur_next.bits  = cur_reg.bits + 7'h01;
          if (cur_reg.st == ST_CMD && cur_reg.bits == 7'(CMD_BITS - 1)) begin
            // Release the line; one continuous stream follows
            cur_next.st   = ST_READ;
            cur_next.bits = 7'h00;
            cur_next.d_oe = 1'b0;
            cur_next.d_o  = 1'b0;
          end else if (cur_reg.st == ST_CMD) begin
            cur_next.d_o = READ_CMD[cmd_idx];
          end else if (cur_reg.bits == 7'(DATA_BITS - 1)) begin
            // All eight bytes in: check markers, then apply or keep defaults
            cur_next.st    = ST_DONE;
            cur_next.done  = 1'b1;
            cur_next.valid = markers_ok;
            cur_next.cfg   = markers_ok ? loaded : CFG_DEFAULT;
          end
        end
      end
      ST_DONE: begin
        // Serial port idle for good; no further commands are issued
        cur_next.clk_o = 1'b0;
        cur_next.d_oe  = 1'b0;
      end
      default: begin
        cur_next = RESET_STATE;
      end
    endcase
    // Results derived from the applied image
    cur_next.rate  = pick_rate(cur_reg.cfg.link[BW_MODE_BIT],
                               cur_reg.cfg.pixel[UP_CLK_LSB +: 2]);
    cur_next.fault = pick_fault(cur_reg.cfg.fault[FAULT_LSB +: 4], sy_stat);
    // Wake-up only trusted with full video timing present
    cur_next.wake  = (cur_reg.cfg.link[WAKE1_BIT] | cur_reg.cfg.fault[WAKE2_BIT] |
                      cur_reg.cfg.fault[WAKE3_BIT]) & sy_stat.video_timing_ok;
    cur_next.side  = side_in;
  end

  // State register; reset restores defaults and forces pins low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_reg <= RESET_STATE;
    end else begin
      cur_reg <= cur_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel word: no reset, so it keeps its last value through reset

  logic [23:0] word_reg;
  logic [2:0]  ctl_reg;

  // Loaded only while the pixel clock is requested and reset is high
  // Reset gates the load instead of clearing, so the word from before reset stays on the pins
  always_ff @(posedge clk) begin
    if (resetn && side_in.pix_clk) begin
      word_reg <= pixel_word_in;
      ctl_reg  <= pixel_control_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cfg_clk_out         = cur_reg.clk_o;
  assign cfg_data_out        = cur_reg.d_o;
  assign cfg_data_oe         = cur_reg.d_oe;
  assign pixel_clk_out       = cur_reg.side.pix_clk;
  assign sideband_down_bits  = cur_reg.side.sb_bits;
  assign sideband_down_clock = cur_reg.side.sb_clk;
  assign pixel_word_out      = word_reg;
  assign pixel_control_out   = ctl_reg;
  assign active_cfg          = cur_reg.cfg;
  assign upstream_rate       = cur_reg.rate;
  assign fault_out           = cur_reg.fault;
  assign wake_enable         = cur_reg.wake;
  assign cfg_done            = cur_reg.done;
  assign cfg_valid           = cur_reg.valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Wait state holds until its full count, clock low meanwhile
  chk_wait_no_clk: assert property ((cur_reg.st == ST_WAIT) |-> !cfg_clk_out)
    else $error("serial clock moved during reset wait");
  chk_wait_length: assert property ((cur_reg.st == ST_WAIT && cur_reg.cnt < WAIT_LAST)
    |=> cur_reg.st == ST_WAIT)
    else $error("reset wait ended early");
  // Clock high phase lasts well beyond one cycle
  chk_clk_high_hold: assert property ($rose(cfg_clk_out) |-> cfg_clk_out[*8])
    else $error("serial clock high phase too short");
  // Data line released whenever the memory is talking
  chk_read_release: assert property ((cur_reg.st == ST_READ) |-> !cfg_data_oe)
    else $error("data line driven during read");
  // Accepted image needs both markers
  chk_valid_markers: assert property ($rose(cfg_valid)
    |-> image_byte(cur_reg.shift, ADDR_START) == CONFIG_START_MARKER
     && image_byte(cur_reg.shift, ADDR_END) == CONFIG_END_MARKER)
    else $error("image accepted with bad marker");
  chk_bad_defaults: assert property (($rose(cfg_done) && !cfg_valid)
    |-> active_cfg == CFG_DEFAULT)
    else $error("rejected image not replaced by defaults");
  chk_early_defaults: assert property (!cfg_done |-> active_cfg == CFG_DEFAULT)
    else $error("settings changed before end marker check");
  // Error pin follows the selected source one cycle later
  chk_fault_lock: assert property ((active_cfg.fault[FAULT_LSB +: 4] == FSEL_PIX_LOCK
    && $stable(active_cfg)) |=> fault_out == !$past(sy_stat.pixel_lock))
    else $error("lock status not inverted on error pin");
  chk_fault_rsvd: assert property ((active_cfg.fault[FAULT_LSB +: 4] inside {[4'h4:4'h6],
    [4'h8:4'hf]}) && $stable(active_cfg) |=> !fault_out)
    else $error("reserved code drives error pin");
  chk_rate_half: assert property ((active_cfg.link[BW_MODE_BIT]
    && active_cfg.pixel[UP_CLK_LSB +: 2] == 2'h2) && $stable(active_cfg)
    |=> upstream_rate == RATE_20M83)
    else $error("wrong upstream rate in 500 Mbit/s mode");
  // Pixel word frozen while no pixel clock is requested
  chk_pixel_hold: assert property (!side_in.pix_clk |=> $stable(pixel_word_out))
    else $error("pixel word changed without pixel clock");

endmodule

// [cfg_memory_model.sv]
// Behavioural serial configuration memory that answers the loader
`timescale 1ns/100ps
module cfg_memory_model (
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        din,
  input  wire logic [63:0] image,
  output logic             mem_do,
  output logic [9:0]       cmd_seen,
  output logic [7:0]       rises
);
  ////////////////////////////////////////////////////////////////////////////////
  // Command capture, then the whole image streamed on one command
  // Data changes just after our rise, so it is settled long before the next
  always @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      rises    <= 8'h00;
      cmd_seen <= 10'h000;
      mem_do   <= 1'b0;
    end else begin
      rises <= rises + 8'h01;
      if (rises < 8'd10) begin
        cmd_seen <= {cmd_seen[8:0], din};
      end
      if (rises >= 8'd9 && rises < 8'd73) begin
        mem_do <= image[8'd63 - (rises - 8'd9)];
      end else begin
        // Released line shows no stale bit
        mem_do <= ~mem_do;
      end
    end
  end
endmodule

// [serial_config_loader_reset_bench.sv]
// Self-checking bench for the serial configuration loader
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module serial_config_loader_reset_bench;
  import cfg_loader_pkg::*;
  logic          clk;
  logic          resetn;
  logic          cfg_clk_out;
  logic          cfg_data_in;
  logic          cfg_data_out;
  logic          cfg_data_oe;
  link_status_t  status_in;
  pixel_side_t   side_in;
  logic [23:0]   pixel_word_in;
  logic [2:0]    pixel_control_in;
  logic          pixel_clk_out;
  logic [23:0]   pixel_word_out;
  logic [2:0]    pixel_control_out;
  logic [1:0]    sideband_down_bits;
  logic          sideband_down_clock;
  config_image_t active_cfg;
  up_rate_t      upstream_rate;
  logic          fault_out;
  logic          wake_enable;
  logic          cfg_done;
  logic          cfg_valid;
  logic          mem_do;
  logic [9:0]    cmd_seen;
  logic [7:0]    rises;
  logic [63:0]   image;
  int            fails;
  int            checks_done;
  int            cyc = 0;
  int            n;

  ////////////////////////////////////////////////////////////////////////////////
  // Design, memory model and the shared data wire
  serial_config_loader_reset dut_u (
    .clk(clk), .resetn(resetn), .cfg_clk_out(cfg_clk_out), .cfg_data_in(cfg_data_in),
    .cfg_data_out(cfg_data_out), .cfg_data_oe(cfg_data_oe), .status_in(status_in),
    .side_in(side_in), .pixel_word_in(pixel_word_in), .pixel_control_in(pixel_control_in),
    .pixel_clk_out(pixel_clk_out), .pixel_word_out(pixel_word_out),
    .pixel_control_out(pixel_control_out), .sideband_down_bits(sideband_down_bits),
    .sideband_down_clock(sideband_down_clock), .active_cfg(active_cfg),
    .upstream_rate(upstream_rate), .fault_out(fault_out), .wake_enable(wake_enable),
    .cfg_done(cfg_done), .cfg_valid(cfg_valid)
  );

  cfg_memory_model mem_u (
    .resetn(resetn), .sclk(cfg_clk_out), .din(cfg_data_out), .image(image),
    .mem_do(mem_do), .cmd_seen(cmd_seen), .rises(rises)
  );

  // Device drives the wire during the command, the memory afterwards
  assign cfg_data_in = cfg_data_oe ? cfg_data_out : mem_do;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; four loads need about 97000 cycles
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      fails++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic config_image_t img_cfg(input logic [63:0] img);
    return {img[15:8], img[23:16], img[31:24], img[39:32], img[47:40], img[55:48]};
  endfunction

  task automatic settle(input int k);
    repeat (k) @(negedge clk);
  endtask

  // One whole load; reset held long enough for the real part as well
  task automatic run_load(input logic [63:0] img, input logic ok);
    image = img;
    resetn = 1'b0;
    settle(80);
    `CHK(active_cfg, CFG_DEFAULT)
    `CHK(cfg_data_oe, 1'b0)
    resetn = 1'b1;
    n = 0;
    while (cfg_clk_out !== 1'b1 && n < 1000) begin
      settle(1);
      n++;
    end
    `CHK(n >= WAIT_MIN_CYC, 1'b1)
    `CHK(upstream_rate, RATE_31M25)
    status_in.no_video = 1'b1;
    settle(5);
    `CHK(fault_out, 1'b1)
    status_in.no_video = 1'b0;
    settle(5);
    `CHK(fault_out, 1'b0)
    // Midway the defaults must still be in force
    settle(10000);
    `CHK(active_cfg, CFG_DEFAULT)
    n = 0;
    while (cfg_done !== 1'b1 && n < 30000) begin
      settle(1);
      n++;
    end
    `CHK(cfg_done, 1'b1)
    `CHK(cfg_valid, ok)
    `CHK(active_cfg, ok ? img_cfg(img) : CFG_DEFAULT)
    `CHK(cmd_seen, 10'h300)
    settle(350);
    `CHK(rises, 8'h4a)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    resetn = 1'b0;
    status_in = '0;
    side_in = '0;
    pixel_word_in = 24'h000000;
    pixel_control_in = 3'h0;
    image = 64'h0;
    fails = 0;
    checks_done = 0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    // Pixel side in reset: clocks low, last word held
    side_in = '1;
    pixel_word_in = 24'h5a3c81;
    pixel_control_in = 3'h5;
    settle(2);
    resetn = 1'b0;
    pixel_word_in = 24'h123456;
    pixel_control_in = 3'h2;
    settle(2);
    `CHK(pixel_word_out, 24'h5a3c81)
    `CHK(pixel_control_out, 3'h5)
    `CHK({pixel_clk_out, sideband_down_bits, sideband_down_clock}, 4'h0)
    resetn = 1'b1;
    settle(2);
    `CHK(pixel_clk_out, 1'b1)
    `CHK(pixel_word_out, 24'h123456)
    `CHK(pixel_control_out, 3'h2)
    `CHK({sideband_down_bits, sideband_down_clock}, 3'h7)
    side_in = '0;
    $display("Test pixel reset finished");
    // Good image, 1G mode, buffer fault code with wake-up bit
    run_load(64'hbd09bc720c000099, 1'b1);
    `CHK(upstream_rate, RATE_41M67)
    status_in.buf_empty = 1'b1;
    settle(5);
    `CHK(fault_out, 1'b1)
    status_in.buf_empty = 1'b0;
    status_in.buf_full = 1'b1;
    settle(5);
    `CHK(fault_out, 1'b1)
    status_in.buf_full = 1'b0;
    status_in.no_video = 1'b1;
    settle(5);
    `CHK(fault_out, 1'b0)
    status_in.no_video = 1'b0;
    status_in.video_timing_ok = 1'b1;
    settle(5);
    `CHK(wake_enable, 1'b1)
    status_in.video_timing_ok = 1'b0;
    settle(5);
    `CHK(wake_enable, 1'b0)
    $display("Test good image finished");
    // Bad end marker: a 20.83 MHz field must not be applied
    run_load(64'hbdc9bc080c000098, 1'b0);
    `CHK(upstream_rate, RATE_31M25)
    $display("Test bad end marker finished");
    // Bad start marker
    run_load(64'hbc09bc720c000099, 1'b0);
    `CHK(upstream_rate, RATE_31M25)
    $display("Test bad start marker finished");
    // Good image, 500M mode at 20.83 MHz, lock code, no wake-up bits
    run_load(64'hbd49bc180c000099, 1'b1);
    `CHK(upstream_rate, RATE_20M83)
    status_in.pixel_lock = 1'b1;
    settle(5);
    `CHK(fault_out, 1'b0)
    status_in.pixel_lock = 1'b0;
    settle(5);
    `CHK(fault_out, 1'b1)
    status_in.video_timing_ok = 1'b1;
    settle(5);
    `CHK(wake_enable, 1'b0)
    status_in.video_timing_ok = 1'b0;
    $display("Test lock code finished");
    end_sim();
  end
endmodule
